// *** rtl/ssc_regs.svh ***
// Purpose: Field positions, reset values and masks of the stepper setup registers
// Assumes: Included by bare name from design files
// Notes: Definitions only
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// ****************************************
// Module setup word fields
// ****************************************
`define SSC_SETUP_SEL1_BIT 0
`define SSC_SETUP_SEL2_BIT 1
`define SSC_SETUP_NVAL_LO 3
`define SSC_SETUP_NVAL_HI 4
`define SSC_SETUP_MRES_LO 5
`define SSC_SETUP_MRES_HI 6
`define SSC_SETUP_MODE_BIT 11
`define SSC_SETUP_RSV_MASK 16'hF784
`define SSC_SETUP_RESET 16'h0000
`define SSC_PRESET_RESET 16'h0000

// ****************************************
// Step command word fields
// ****************************************
`define SSC_STEP_CNT_HI 12
`define SSC_STEP_DIR_BIT 13
`define SSC_STEP_CUR_LO 14
`define SSC_STEP_CUR_HI 15
`define SSC_MICRO_BASE 4'h5

// ****************************************
// Status byte positions
// ****************************************
`define SSC_ST_SUPPLY 0
`define SSC_ST_RSV 1
`define SSC_ST_TOG1 2
`define SSC_ST_DONE1 3
`define SSC_ST_IN3 4
`define SSC_ST_TOG2 5
`define SSC_ST_DONE2 6
`define SSC_ST_IN6 7

`endif

// *** rtl/ssc_pkg.sv ***
// Purpose: Types shared by the stepper setup and status block
// Assumes: Nothing
// Notes: Constants live in ssc_regs.svh
package ssc_pkg;

    // Homing state of one encoder counter
    typedef enum logic [2:0] {
        SSC_HOME_IDLE = 3'b001,
        SSC_HOME_BUSY = 3'b010,
        SSC_HOME_DONE = 3'b100
    } ssc_home_e;

    // Transfer value count codes
    typedef enum logic [1:0] {
        SSC_NVAL_ONE = 2'b00,
        SSC_NVAL_TWO = 2'b01,
        SSC_NVAL_FOUR = 2'b10,
        SSC_NVAL_RSV = 2'b11
    } ssc_nval_e;

    typedef logic [15:0] ssc_word_t;

endpackage

// *** rtl/ssc_slice_if.sv ***
// Purpose: Carries slice timing between the slicer and the register block
// Assumes: Single clock domain
// Notes: slice_go is a one-cycle pulse
`timescale 1ns/1ns
interface ssc_slice_if;
    ssc_pkg::ssc_nval_e nval;
    logic slice_go;
    logic [1:0] slot;

    modport slicer (
        input nval,
        output slice_go,
        output slot
    );
    modport user (
        output nval,
        input slice_go,
        input slot
    );
endinterface

// *** rtl/ssc_slicer.sv ***
// Purpose: Splits each bus cycle into one, two or four equal step slices
// Assumes: cyc_start pulses once per bus cycle in the mclk domain
// Notes: Slice length comes from the previous bus cycle length
`timescale 1ns/1ns
module ssc_slicer #(
    parameter int PER_W = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cyc_start,
    ssc_slice_if.slicer sif
);

    typedef struct packed {
        logic [PER_W-1:0] cnt;
        logic [PER_W-1:0] period;
        logic [PER_W-1:0] scnt;
        logic [1:0] slot;
        logic go;
    } ssc_slicer_s;

    ssc_slicer_s st;
    ssc_slicer_s next_st;
    logic [1:0] shift;
    logic [1:0] last;
    logic [PER_W-1:0] slen;

    // Width check
    if (PER_W < 4) begin : g_chk
        $error("ssc_slicer: PER_W must be at least 4");
    end

    // ****************************************
    // Slice decode
    // ****************************************
    always_comb begin
        unique case (sif.nval)
            ssc_pkg::SSC_NVAL_TWO: shift = 2'h1;
            ssc_pkg::SSC_NVAL_FOUR: shift = 2'h2;
            default: shift = 2'h0; // One value, reserved code too
        endcase
        last = 2'((3'h1 << shift) - 3'h1);
        slen = st.period >> shift;
    end

    // Cycle measure and slot stepping
    always_comb begin
        next_st = st;
        next_st.go = 1'b0;
        if (!(&st.cnt)) begin
            next_st.cnt = st.cnt + 1'b1;
        end
        next_st.scnt = st.scnt + 1'b1;
        if (cyc_start) begin
            next_st.period = st.cnt + 1'b1;
            next_st.cnt = '0;
            next_st.scnt = '0;
            next_st.slot = 2'h0;
            next_st.go = 1'b1;
        end else if (slen != '0 && next_st.scnt >= slen && st.slot < last) begin
            next_st.slot = st.slot + 2'h1;
            next_st.scnt = '0;
            next_st.go = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sif.slice_go = st.go;
    assign sif.slot = st.slot;

endmodule

// *** rtl/ssc_top.sv ***
// Purpose: Homing preset, status byte and module setup word of a two-axis stepper
// Assumes: Controller writes arrive as mclk-domain strobes; pins are asynchronous
// Notes: One status byte and one setup word per module; one preset per axis
//        Homing load wins over a slice advance in the same cycle
//        Reserved transfer code runs as one value per bus cycle
//        Done bits read 0 in homing view until the first homing after reset
//        First bus cycle after reset takes its slice length from the time since reset
//        Status lags a pin by three cycles through the synchronisers
//        Reference mark edges outside homing are ignored
//
// Operation
// - Homing loads the axis position counter with that axis preset value.
// - Status bit 0 is 1 on supply fault, 0 when supply is good.
// - Bit 2: input 1, or toggles per encoder 1 homing completion.
// - Bit 3: input 2, or 0 while encoder 1 homes, 1 once done.
// - Bit 5: input 4, or toggles per encoder 2 homing completion.
// - Bit 6: input 5, or 0 while encoder 2 homes, 1 once done.
// - Bits 4 and 7 always show inputs 3 and 6.
// - Setup bits 0 and 1 pick inputs or homing view per encoder.
// - Setup bits 3-4 pick one, two or four values; 11 reserved.
// - Setup bits 5-6 give 5 to 8 microstep bits; rest full steps.
// - Setup bit 11 selects normal mode at 0, enhanced at 1.
// - Two or four values split the bus cycle in equal slices.
`timescale 1ns/1ns
`include "ssc_regs.svh"
module ssc_top #(
    parameter int PER_W = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cyc_start,
    input wire logic preset_wr,
    input wire logic preset_axis,
    input wire logic [15:0] preset_data,
    input wire logic setup_wr,
    input wire logic [15:0] setup_data,
    input wire logic [1:0][3:0][15:0] step_command_words,
    input wire logic [5:0] din_pin,
    input wire logic supply_fault_pin,
    input wire logic [1:0] home_start,
    input wire logic [1:0] ref_mark_pin,
    output logic [7:0] input_and_homing_flags,
    output logic [15:0] module_setup_word,
    output logic [1:0][15:0] homing_preset_value,
    output logic [1:0][15:0] pos_count,
    output logic [1:0][15:0] step_command_slot,
    output logic [1:0][7:0] step_micro,
    output logic [1:0][7:0] step_full,
    output logic [1:0][1:0] cur_sel,
    output logic [1:0] step_dir,
    output logic [1:0] slot_index,
    output logic enhanced_mode
);

    // ****************************************
    // State record
    // ****************************************
    typedef struct packed {
        // Pin synchroniser stages
        logic [5:0] din_s1;
        logic [5:0] din_s2;
        logic sf_s1;
        logic sf_s2;
        logic [1:0] ref_s1;
        logic [1:0] ref_s2;
        logic [1:0] ref_s3;
        // Controller registers
        ssc_pkg::ssc_word_t setup;
        logic [1:0][15:0] preset;
        // Homing and status
        ssc_pkg::ssc_home_e [1:0] home;
        logic [1:0] tog;
        logic [7:0] status;
        // Position and step slot outputs
        logic [1:0][15:0] pos;
        logic [1:0][15:0] slot_word;
        logic [1:0][7:0] micro;
        logic [1:0][7:0] full;
        logic [1:0][1:0] cur;
        logic [1:0] dir;
        logic [1:0] slot;
        logic enh;
    } ssc_top_s;

    ssc_top_s st;
    ssc_top_s next_st;
    // Edge and view helpers
    logic [1:0] ref_rise;
    logic [1:0] sel_homing;

    // Slice timing carrier
    ssc_slice_if sif();

    // Width check
    if (PER_W < 4) begin : g_chk
        $error("ssc_top: PER_W must be at least 4");
    end

    // ****************************************
    // Decode helpers
    // ****************************************

    // Microstep width for a resolution code
    function automatic logic [3:0] micro_width(input logic [1:0] code);
        micro_width = `SSC_MICRO_BASE + {2'h0, code};
    endfunction

    // Low microstep bits of a step count
    function automatic logic [7:0] micro_part(input logic [12:0] cnt,
                                              input logic [1:0] code);
        logic [12:0] mask;
        mask = ~(13'h1FFF << micro_width(code));
        micro_part = 8'(cnt & mask);
    endfunction

    // Full-step part of a step count
    function automatic logic [7:0] full_part(input logic [12:0] cnt,
                                             input logic [1:0] code);
        full_part = 8'(cnt >> micro_width(code));
    endfunction

    // Status view: homing indication or pin level
    function automatic logic view_pick(input logic homing_view,
                                       input logic homing_bit,
                                       input logic pin_level);
        view_pick = homing_view ? homing_bit : pin_level;
    endfunction

    // Homing finished for one encoder counter
    function automatic logic home_done(input ssc_pkg::ssc_home_e state);
        home_done = (state == ssc_pkg::SSC_HOME_DONE);
    endfunction

    // Position after one step slot; direction bit set counts down
    function automatic logic [15:0] step_move(input logic [15:0] pos,
                                              input logic [15:0] word);
        logic [15:0] delta;
        delta = {3'h0, word[`SSC_STEP_CNT_HI:0]};
        if (word[`SSC_STEP_DIR_BIT]) begin
            step_move = pos - delta;
        end else begin
            step_move = pos + delta;
        end
    endfunction

    // ****************************************
    // Slice timing
    // ****************************************
    assign sif.nval = ssc_pkg::ssc_nval_e'(
        st.setup[`SSC_SETUP_NVAL_HI:`SSC_SETUP_NVAL_LO]);

    ssc_slicer #(
        .PER_W(PER_W)
    ) u_slicer (
        .mclk(mclk),
        .resetn(resetn),
        .cyc_start(cyc_start),
        .sif(sif)
    );

    // Homing view selects per encoder
    assign sel_homing = {st.setup[`SSC_SETUP_SEL2_BIT],
                         st.setup[`SSC_SETUP_SEL1_BIT]};

    // Reference mark rising edges, taken after the second stage
    assign ref_rise = st.ref_s2 & ~st.ref_s3;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;

        // ****************************************
        // Pins and controller writes
        // ****************************************
        // Pin synchronisers
        next_st.din_s1 = din_pin;
        next_st.din_s2 = st.din_s1;
        next_st.sf_s1 = supply_fault_pin;
        next_st.sf_s2 = st.sf_s1;
        next_st.ref_s1 = ref_mark_pin;
        next_st.ref_s2 = st.ref_s1;
        next_st.ref_s3 = st.ref_s2;

        // Controller writes; reserved setup bits are dropped
        if (setup_wr) begin
            next_st.setup = setup_data & ~`SSC_SETUP_RSV_MASK;
        end
        if (preset_wr) begin
            next_st.preset[preset_axis] = preset_data;
        end

        // Mode flag
        next_st.enh = st.setup[`SSC_SETUP_MODE_BIT];

        // ****************************************
        // Step slices
        // ****************************************
        // Step slot latch and position advance
        if (sif.slice_go) begin
            next_st.slot = sif.slot;
        end
        for (int a = 0; a < 2; a++) begin
            if (sif.slice_go) begin
                next_st.slot_word[a] = step_command_words[a][sif.slot];
                next_st.pos[a] = step_move(st.pos[a],
                    step_command_words[a][sif.slot]);
            end

            // Step word split into fields
            next_st.micro[a] = micro_part(st.slot_word[a][`SSC_STEP_CNT_HI:0],
                st.setup[`SSC_SETUP_MRES_HI:`SSC_SETUP_MRES_LO]);
            next_st.full[a] = full_part(st.slot_word[a][`SSC_STEP_CNT_HI:0],
                st.setup[`SSC_SETUP_MRES_HI:`SSC_SETUP_MRES_LO]);
            next_st.dir[a] = st.slot_word[a][`SSC_STEP_DIR_BIT];
            next_st.cur[a] =
                st.slot_word[a][`SSC_STEP_CUR_HI:`SSC_STEP_CUR_LO];

            // ****************************************
            // Homing
            // ****************************************
            // Homing sequence per encoder counter
            unique case (st.home[a])
                ssc_pkg::SSC_HOME_IDLE,
                ssc_pkg::SSC_HOME_DONE: begin
                    if (home_start[a]) begin
                        next_st.home[a] = ssc_pkg::SSC_HOME_BUSY;
                    end
                end
                ssc_pkg::SSC_HOME_BUSY: begin
                    if (ref_rise[a]) begin
                        next_st.pos[a] = st.preset[a];
                        next_st.home[a] = ssc_pkg::SSC_HOME_DONE;
                        next_st.tog[a] = ~st.tog[a];
                    end
                end
                default: begin
                    next_st.home[a] = ssc_pkg::SSC_HOME_IDLE;
                end
            endcase
        end

        // ****************************************
        // Status byte
        // ****************************************

        // Supply and reserved bits
        next_st.status[`SSC_ST_SUPPLY] = st.sf_s2;
        next_st.status[`SSC_ST_RSV] = 1'b0;

        // Encoder counter 1 view, pins 1 and 2 otherwise
        next_st.status[`SSC_ST_TOG1] =
            view_pick(sel_homing[0], st.tog[0], st.din_s2[0]);
        next_st.status[`SSC_ST_DONE1] =
            view_pick(sel_homing[0], home_done(st.home[0]), st.din_s2[1]);

        // Encoder counter 2 view, pins 4 and 5 otherwise
        next_st.status[`SSC_ST_TOG2] =
            view_pick(sel_homing[1], st.tog[1], st.din_s2[3]);
        next_st.status[`SSC_ST_DONE2] =
            view_pick(sel_homing[1], home_done(st.home[1]), st.din_s2[4]);

        // Pins 3 and 6 shown in every setup
        next_st.status[`SSC_ST_IN3] = st.din_s2[2];
        next_st.status[`SSC_ST_IN6] = st.din_s2[5];
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            // Everything clear, both homing sequences idle
            st <= '0;
            st.setup <= `SSC_SETUP_RESET;
            st.preset <= {2{`SSC_PRESET_RESET}};
            st.home[0] <= ssc_pkg::SSC_HOME_IDLE;
            st.home[1] <= ssc_pkg::SSC_HOME_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs, all straight from the record
    // ****************************************
    assign input_and_homing_flags = st.status;
    assign module_setup_word = st.setup;
    assign homing_preset_value = st.preset;
    assign pos_count = st.pos;
    assign step_command_slot = st.slot_word;
    assign step_micro = st.micro;
    assign step_full = st.full;
    assign cur_sel = st.cur;
    assign step_dir = st.dir;
    assign slot_index = st.slot;
    assign enhanced_mode = st.enh;

endmodule

// *** tb/ssc_top_props.sv ***
// Purpose: Port-level properties of the stepper setup and status block
// Assumes: Bound into ssc_top, one clock domain
// Notes: Input views settle within four stable samples; the properties allow six
`timescale 1ns/1ns
`include "ssc_regs.svh"
module ssc_top_props #(
    parameter int PER_W = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cyc_start,
    input wire logic setup_wr,
    input wire logic [15:0] setup_data,
    input wire logic [5:0] din_pin,
    input wire logic supply_fault_pin,
    input wire logic [1:0] home_start,
    input wire logic [7:0] input_and_homing_flags,
    input wire logic [15:0] module_setup_word,
    input wire logic [1:0][15:0] homing_preset_value,
    input wire logic [1:0][15:0] pos_count,
    input wire logic [1:0] slot_index,
    input wire logic enhanced_mode
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    AST_SUPPLY: assert property (supply_fault_pin [*6] |-> input_and_homing_flags[0])
        else $error("supply fault not shown");
    AST_RSV_BIT: assert property (input_and_homing_flags[1] == 1'b0)
        else $error("reserved status bit set");
    AST_IN1_VIEW: assert property ((!module_setup_word[0] && din_pin[0]) [*6]
        |-> input_and_homing_flags[2]) else $error("input 1 not shown");
    AST_IN6: assert property (din_pin[5] [*6] |-> input_and_homing_flags[7])
        else $error("input 6 not shown");
    AST_BUSY0: assert property (home_start[0] && module_setup_word[0]
        ##1 module_setup_word[0] [*2] |-> !input_and_homing_flags[3])
        else $error("homing not shown as active");
    AST_HOME_LOAD: assert property ($rose(input_and_homing_flags[3]) &&
        module_setup_word[0] && $past(module_setup_word[0], 2)
        |-> $past(pos_count[0]) == homing_preset_value[0]) else $error("preset not loaded");
    AST_TOGGLE1: assert property ($rose(input_and_homing_flags[3]) &&
        module_setup_word[0] && $past(module_setup_word[0], 2)
        |-> input_and_homing_flags[2] != $past(input_and_homing_flags[2]))
        else $error("toggle bit did not flip");
    AST_SETUP_ECHO: assert property (setup_wr |=>
        module_setup_word == ($past(setup_data) & ~`SSC_SETUP_RSV_MASK))
        else $error("setup readback wrong");
    AST_MODE: assert property (setup_wr |-> ##2 enhanced_mode == $past(setup_data[11], 2))
        else $error("mode bit wrong");
    AST_SLOT0: assert property (cyc_start |-> ##2 slot_index == 2'h0)
        else $error("slot 0 not first");
endmodule

bind ssc_top ssc_top_props #(.PER_W(PER_W)) u_props (
    .mclk(mclk), .resetn(resetn), .cyc_start(cyc_start), .setup_wr(setup_wr),
    .setup_data(setup_data), .din_pin(din_pin), .supply_fault_pin(supply_fault_pin),
    .home_start(home_start), .input_and_homing_flags(input_and_homing_flags),
    .module_setup_word(module_setup_word), .homing_preset_value(homing_preset_value),
    .pos_count(pos_count), .slot_index(slot_index), .enhanced_mode(enhanced_mode)
);

// *** tb/ssc_cpu_model.sv ***
// Purpose: Controller side: bus cycle strobe and step command words
// Assumes: Words are static levels between bus cycles
// Notes: Slot k carries count 0x101*(k+1), current k, direction k[0]
`timescale 1ns/1ns
module ssc_cpu_model #(
    parameter int PERIOD = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic run,
    output logic cyc_start,
    output logic [1:0][3:0][15:0] step_command_words
);
    int cnt;

    // Current, direction and count fields of each slot
    always_comb begin
        for (int a = 0; a < 2; a++) begin
            for (int k = 0; k < 4; k++) begin
                step_command_words[a][k] = {k[1:0], k[0], 13'(16'h0101 * (k + 1))};
            end
        end
    end

    // One-cycle strobe every PERIOD clocks while running
    always_ff @(posedge mclk) begin
        if (!resetn || !run) begin
            cnt <= 0;
            cyc_start <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            cyc_start <= (cnt == 0);
        end
    end
endmodule

// *** tb/tb_stepper_io_status_config.sv ***
// Purpose: Self-checking bench for the stepper setup and status block
// Assumes: Controller model drives bus cycle strobe and step words
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module tb_stepper_io_status_config;
    logic mclk, resetn, cyc_start, preset_wr, preset_axis, setup_wr, supply_fault_pin, run;
    logic [15:0] preset_data, setup_data, module_setup_word;
    logic [1:0][3:0][15:0] step_command_words;
    logic [5:0] din_pin;
    logic [1:0] home_start, ref_mark_pin, step_dir, slot_index;
    logic [7:0] input_and_homing_flags;
    logic [1:0][15:0] homing_preset_value, pos_count, step_command_slot;
    logic [1:0][7:0] step_micro, step_full;
    logic [1:0][1:0] cur_sel;
    logic enhanced_mode;
    int err_count = 0;
    int compares = 0;

    ssc_top #(.PER_W(16)) u_dut (
        .mclk(mclk), .resetn(resetn), .cyc_start(cyc_start), .preset_wr(preset_wr),
        .preset_axis(preset_axis), .preset_data(preset_data), .setup_wr(setup_wr),
        .setup_data(setup_data), .step_command_words(step_command_words), .din_pin(din_pin),
        .supply_fault_pin(supply_fault_pin), .home_start(home_start),
        .ref_mark_pin(ref_mark_pin), .input_and_homing_flags(input_and_homing_flags),
        .module_setup_word(module_setup_word), .homing_preset_value(homing_preset_value),
        .pos_count(pos_count), .step_command_slot(step_command_slot),
        .step_micro(step_micro), .step_full(step_full), .cur_sel(cur_sel),
        .step_dir(step_dir), .slot_index(slot_index), .enhanced_mode(enhanced_mode)
    );
    ssc_cpu_model #(.PERIOD(8)) u_cpu (
        .mclk(mclk), .resetn(resetn), .run(run), .cyc_start(cyc_start),
        .step_command_words(step_command_words)
    );

    // ********
    // Helpers
    // ********
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [15:0] exp_word(input logic [1:0] k);
        return {k, k[0], 13'h0101 * (13'(k) + 13'h1)};
    endfunction
    task automatic wr_setup(input logic [15:0] v);
        setup_data = v;
        setup_wr = 1'b1;
        tick(1);
        setup_wr = 1'b0;
        tick(3);
    endtask
    task automatic wr_preset(input logic a, input logic [15:0] v);
        preset_axis = a;
        preset_data = v;
        preset_wr = 1'b1;
        tick(1);
        preset_wr = 1'b0;
        tick(3);
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset;
        resetn = 1'b0;
        tick(6);
        resetn = 1'b1;
        tick(1);
        check(module_setup_word, 16'h0000);
        check(homing_preset_value[0], 16'h0000);
        check(homing_preset_value[1], 16'h0000);
        check(pos_count[0], 16'h0000);
    endtask
    task automatic t_setup;
        logic [15:0] vals [4] = '{16'hFFFF, 16'h0818, 16'h0860, 16'h0000};
        foreach (vals[i]) begin
            wr_setup(vals[i]);
            check(module_setup_word, vals[i] & 16'h087B);
            check(enhanced_mode, 16'(vals[i][11]));
        end
    endtask
    task automatic t_inputs;
        for (int i = 0; i < 7; i++) begin
            din_pin = (i == 6) ? 6'h3F : 6'(1 << i);
            supply_fault_pin = i[0];
            tick(8);
            check(input_and_homing_flags, {din_pin, 1'b0, supply_fault_pin});
        end
    endtask
    task automatic t_home(input int a, input logic [15:0] pre, input logic [15:0] tog);
        int tb = a ? 5 : 2;
        int db = a ? 6 : 3;
        home_start[a] = 1'b1;
        tick(1);
        home_start[a] = 1'b0;
        tick(3);
        check(input_and_homing_flags[db], 16'h0000);
        check({input_and_homing_flags[7], input_and_homing_flags[4]}, 16'h0003);
        ref_mark_pin[a] = 1'b1;
        tick(8);
        ref_mark_pin[a] = 1'b0;
        check(pos_count[a], pre);
        check(input_and_homing_flags[db], 16'h0001);
        check(input_and_homing_flags[tb], tog);
    endtask
    task automatic t_slices;
        logic [3:0] seen;
        logic [15:0] w;
        logic [15:0] wp;
        logic [15:0] p0;
        logic [15:0] dp;
        run = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr_setup(16'((i << 5) | (i << 3)));
            tick(24);
            for (int c = 0; c < 16 && cyc_start !== 1'b1; c++) begin
                tick(1);
            end
            seen = 4'h0;
            wp = exp_word(slot_index);
            p0 = pos_count[0];
            for (int c = 0; c < 8; c++) begin
                tick(1);
                seen[slot_index] = 1'b1;
                w = exp_word(slot_index);
                // Field outputs follow the latched word one cycle later
                for (int a = 0; a < 2; a++) begin
                    check(step_command_slot[a], w);
                    check({step_dir[a], cur_sel[a]}, 16'({wp[13], wp[15:14]}));
                    check(step_micro[a], 16'(wp[12:0] & ((13'h1 << (5 + i)) - 1)));
                    check(step_full[a], 16'(wp[12:0] >> (5 + i)));
                end
                wp = w;
            end
            check(seen, (i == 1) ? 16'h0003 : (i == 2) ? 16'h000F : 16'h0001);
            // Net move over one bus cycle of slots
            dp = (i == 1) ? 16'hFEFF : (i == 2) ? 16'hFDFE : 16'h0101;
            check(16'(pos_count[0] - p0), dp);
        end
        run = 1'b0;
    endtask

    // ********
    // Main sequence and watchdog
    // ********
    initial begin
        {resetn, run, preset_wr, preset_axis, setup_wr, supply_fault_pin} = 6'h00;
        {preset_data, setup_data, din_pin, home_start, ref_mark_pin} = 42'h0;
        t_reset;
        t_setup;
        wr_preset(1'b0, 16'h1234);
        wr_preset(1'b1, 16'hFFFF);
        check(homing_preset_value[0], 16'h1234);
        check(homing_preset_value[1], 16'hFFFF);
        t_inputs;
        din_pin = 6'h24;
        wr_setup(16'h0003);
        t_home(0, 16'h1234, 16'h0001);
        t_home(1, 16'hFFFF, 16'h0001);
        wr_preset(1'b0, 16'h0F0F);
        t_home(0, 16'h0F0F, 16'h0000);
        t_slices;
        t_reset;
        stop_test;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        stop_test;
    end
endmodule
